// ### rtl/tps_map.svh
/*
   Register offsets, field positions, reset values and timing counts of the timer
   prescaler block.
   Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
*/
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

// Register byte offsets.
`define TPS_OFF_COUNT 8'h00
`define TPS_OFF_CONFIG 8'h04
`define TPS_OFF_WDCLR 8'h08
`define TPS_OFF_STATUS 8'h0C

// Configuration field positions.
`define TPS_CFG_RATIO_LSB 0
`define TPS_CFG_RATIO_MSB 2
`define TPS_CFG_ASSIGN_BIT 3
`define TPS_CFG_EDGE_BIT 4
`define TPS_CFG_SRC_BIT 5
`define TPS_CFG_WIDTH 6

// Watchdog clear command bit.
`define TPS_WDCLR_BIT 0

// Reset values.
`define TPS_CFG_RESET 6'h3F
`define TPS_COUNT_RESET 8'h00
`define TPS_PRESCALE_RESET 8'h00

// Timing counts, in instruction cycles and oscillator periods.
`define TPS_INHIBIT_CYCLES 2'h2
`define TPS_OSC_PERIOD_NS 20
`define TPS_PHASES_PER_CYCLE 4

`endif

// ### rtl/tps_pkg.sv
/*
   Types and shared functions of the timer prescaler block.
   Uses literal numbers only; no constant of tps_map.svh is used here.
*/
package tps_pkg;

   typedef enum logic [1:0] {
      TPS_Q1 = 2'b00,
      TPS_Q2 = 2'b01,
      TPS_Q3 = 2'b10,
      TPS_Q4 = 2'b11
   } tps_phase_t;

   // Mask of the scaler bits below the selected ratio bit.
   function automatic logic [7:0] tps_low_mask(input logic [2:0] ratio);
      tps_low_mask = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(ratio)) begin
            tps_low_mask[i] = 1'b1;
         end
      end
   endfunction : tps_low_mask

endpackage : tps_pkg

// ### rtl/tps_sync2.sv
/*
   Two flip-flop level synchroniser for one pin input.
   Assumes the input is asynchronous to ref_clk; only the second stage is read.
*/
`timescale 1ns/100ps
module tps_sync2 (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // Level in and out.
   input wire logic din,
   output logic dout
);
   logic stage1;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : tps_sync2

// ### rtl/tps_scaler.sv
/*
   Shared 8-bit prescaler counter with divided output and postscale tick.
   Assumes advance and clear are one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
`include "tps_map.svh"
module tps_scaler #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // Control.
   input wire logic clear,
   input wire logic advance,
   input wire logic [2:0] ratio,
   // Results.
   output logic div_out,
   output logic tick
);
   logic [WIDTH-1:0] cnt;
   logic [7:0] mask;

   // The count is hidden from software and zero after reset.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= WIDTH'(`TPS_PRESCALE_RESET);
      end else if (clear) begin
         cnt <= '0;
      end else if (advance) begin
         cnt <= cnt + 1'b1;
      end
   end

   always_comb begin
      mask = tps_pkg::tps_low_mask(ratio);
      div_out = cnt[ratio];
      tick = advance && ((cnt[7:0] & mask) == mask);
   end
endmodule : tps_scaler

// ### rtl/tps_timer.sv
/*
   Timer/counter with external count input and shared prescaler, APB register access.
   Assumes an APB master on ref_clk, an asynchronous count pin, and a watchdog that
   supplies a base tick on ref_clk and takes a clear pulse and timeout tick.
*/
// Our own choices: the register addresses and the APB slave port.
// How it works
// - With watchdog assignment the count input goes straight to the sampler.
// - The prescaler output is sampled in the second and fourth phases.
// - With timer assignment the input is divided so the output is symmetrical.
// - The count increments three to six oscillator periods after an input change.
// - One 8-bit counter scales either the timer or the watchdog, never both.
// - Assignment and ratio come from the low four configuration bits.
// - With timer assignment every count register write clears the prescaler.
// - With watchdog assignment the watchdog clear also clears the prescaler.
// - The prescaler is hidden from software and zero after any reset.
// - The assignment may change at any time without stopping the timer.
// - A cleared assignment bit selects the timer, ratios 1:2 to 1:256.
// - Timer mode counts each instruction cycle; writes inhibit two cycles.
// - Counter mode counts input edges; the edge bit selects rising or falling.
`timescale 1ns/100ps
`include "tps_map.svh"
module tps_timer (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External count pin.
   input wire logic ext_count_input,
   // Watchdog side.
   input wire logic wdt_base_tick,
   output logic watchdog_clear_instr,
   output logic wdt_timeout_tick
);
   tps_pkg::tps_phase_t phase;
   tps_pkg::tps_phase_t next_phase;
   logic [7:0] count_register;
   logic [`TPS_CFG_WIDTH-1:0] config_reg;
   logic [1:0] inhibit;
   logic ext_sync;
   logic ext_lvl;
   logic ext_lvl_d;
   logic ext_edge;
   logic sample;
   logic inc_pulse;
   logic setup;
   logic wr_access;
   logic wr_count;
   logic wr_config;
   logic wr_wdclr;
   logic mapped;
   logic prescaler_assign_select;
   logic [2:0] prescale_ratio_field;
   logic count_source_select;
   logic count_edge_select;
   logic is_q2_q4;
   logic scale_clear;
   logic scale_advance;
   logic scale_div;
   logic scale_tick;
   logic pre_out;
   logic use_sampler;
   logic wd_clear_cmd;

   // Configuration fields.
   assign prescaler_assign_select = config_reg[`TPS_CFG_ASSIGN_BIT];
   assign prescale_ratio_field = config_reg[`TPS_CFG_RATIO_MSB:`TPS_CFG_RATIO_LSB];
   assign count_source_select = config_reg[`TPS_CFG_SRC_BIT];
   assign count_edge_select = config_reg[`TPS_CFG_EDGE_BIT];

   // Bus decode; the slave always answers in the access phase.
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign wr_count = wr_access && (paddr == `TPS_OFF_COUNT);
   assign wr_config = wr_access && (paddr == `TPS_OFF_CONFIG);
   assign wr_wdclr = wr_access && (paddr == `TPS_OFF_WDCLR);
   assign wd_clear_cmd = wr_wdclr && pwdata[`TPS_WDCLR_BIT];

   always_comb begin
      case (paddr)
         `TPS_OFF_COUNT: mapped = 1'b1;
         `TPS_OFF_CONFIG: mapped = 1'b1;
         `TPS_OFF_WDCLR: mapped = 1'b1;
         `TPS_OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !mapped;

   // Read data is captured in the setup cycle and stands through the access phase.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (paddr)
            `TPS_OFF_COUNT: prdata <= {24'h00_0000, count_register};
            `TPS_OFF_CONFIG: prdata <= {26'h000_0000, config_reg};
            `TPS_OFF_STATUS: prdata <= {26'h000_0000, inhibit, sample, 1'b0, phase};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration register; writes take effect at once, the timer keeps running.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         config_reg <= `TPS_CFG_RESET;
      end else if (wr_config) begin
         config_reg <= pwdata[`TPS_CFG_WIDTH-1:0];
      end
   end

   // Watchdog clear pulse towards the watchdog counter.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_clear_instr <= 1'b0;
      end else begin
         watchdog_clear_instr <= wd_clear_cmd;
      end
   end

   // Phase sequencer: each phase lasts one oscillator period.
   always_comb begin
      case (phase)
         tps_pkg::TPS_Q1: next_phase = tps_pkg::TPS_Q2;
         tps_pkg::TPS_Q2: next_phase = tps_pkg::TPS_Q3;
         tps_pkg::TPS_Q3: next_phase = tps_pkg::TPS_Q4;
         tps_pkg::TPS_Q4: next_phase = tps_pkg::TPS_Q1;
         default: next_phase = tps_pkg::TPS_Q1;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         phase <= tps_pkg::TPS_Q1;
      end else begin
         phase <= next_phase;
      end
   end

   assign is_q2_q4 = (phase == tps_pkg::TPS_Q2) || (phase == tps_pkg::TPS_Q4);

   // Pin synchroniser; edge selection inverts the level for falling edges.
   tps_sync2 u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .din(ext_count_input),
      .dout(ext_sync)
   );

   assign ext_lvl = ext_sync ^ count_edge_select;

   // The reset configuration selects falling edges, so an idle low pin reads as a high level.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_lvl_d <= 1'b1;
      end else begin
         ext_lvl_d <= ext_lvl;
      end
   end

   assign ext_edge = ext_lvl && !ext_lvl_d;

   // Prescaler steering: the single counter serves the timer or the watchdog.
   always_comb begin
      scale_clear = 1'b0;
      scale_advance = 1'b0;
      if (!prescaler_assign_select) begin
         scale_clear = wr_count;
         if (count_source_select) begin
            scale_advance = ext_edge;
         end else begin
            scale_advance = (phase == tps_pkg::TPS_Q4);
         end
      end else begin
         scale_clear = wd_clear_cmd;
         scale_advance = wdt_base_tick;
      end
   end

   tps_scaler #(
      .WIDTH(8)
   ) u_scaler (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(scale_clear),
      .advance(scale_advance),
      .ratio(prescale_ratio_field),
      .div_out(scale_div),
      .tick(scale_tick)
   );

   // Watchdog timeout: postscaled when assigned, otherwise undivided.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wdt_timeout_tick <= 1'b0;
      end else if (prescaler_assign_select) begin
         wdt_timeout_tick <= scale_tick;
      end else begin
         wdt_timeout_tick <= wdt_base_tick;
      end
   end

   // Signal that the sampler watches.
   always_comb begin
      use_sampler = 1'b1;
      pre_out = 1'b0;
      if (count_source_select) begin
         if (prescaler_assign_select) begin
            pre_out = ext_lvl;
         end else begin
            pre_out = scale_div;
         end
      end else if (!prescaler_assign_select) begin
         pre_out = scale_div;
      end else begin
         use_sampler = 1'b0;
      end
   end

   // Sampler and increment request; a rising sample queues one increment.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sample <= 1'b1;
      end else if (is_q2_q4) begin
         sample <= pre_out;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         inc_pulse <= 1'b0;
      end else if (use_sampler) begin
         inc_pulse <= is_q2_q4 && pre_out && !sample && (inhibit == 2'h0);
      end else begin
         inc_pulse <= (phase == tps_pkg::TPS_Q4) && (inhibit == 2'h0);
      end
   end

   // Increment inhibit after a count write, counted in instruction cycles.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         inhibit <= 2'h0;
      end else if (wr_count) begin
         inhibit <= `TPS_INHIBIT_CYCLES;
      end else if ((phase == tps_pkg::TPS_Q4) && (inhibit != 2'h0)) begin
         inhibit <= inhibit - 2'h1;
      end
   end

   // Count register: a write wins over a pending increment.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_register <= `TPS_COUNT_RESET;
      end else if (wr_count) begin
         count_register <= pwdata[7:0];
      end else if (inc_pulse) begin
         count_register <= count_register + 8'h01;
      end
   end

endmodule : tps_timer

// ### tb/tps_timer_checker.sv
/*
   Port assertions for the timer block.
   Assumes one clock domain; bound to tps_timer below its endmodule.
*/
`timescale 1ns/100ps
module tps_timer_checker (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // Bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Watchdog side.
   input wire logic wdt_base_tick,
   input wire logic watchdog_clear_instr,
   input wire logic wdt_timeout_tick
);
   logic [5:0] cfg;
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire wr = acc && pwrite;
   wire clr_wr = wr && paddr == 8'h08 && pwdata[0];
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Shadow of the configuration register.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= 6'h3F;
      end else if (wr && paddr == 8'h04) begin
         cfg <= pwdata[5:0];
      end
   end
   property p_clr_pulse; clr_wr |=> watchdog_clear_instr; endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse missing");
   property p_clr_cause; watchdog_clear_instr |-> $past(clr_wr); endproperty
   a_clr_cause: assert property (p_clr_cause) else $error("clear pulse uncaused");
   property p_tick_cause; wdt_timeout_tick |-> $past(wdt_base_tick); endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("timeout uncaused");
   property p_tick_pass;
      !wr && wdt_base_tick && (!cfg[3] || cfg[2:0] == 3'h0) |=> wdt_timeout_tick;
   endproperty
   a_tick_pass: assert property (p_tick_pass) else $error("timeout not passed");
   property p_err_map; acc && paddr > 8'h0C |-> pslverr; endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped not refused");
   property p_err_only; pslverr |-> acc && paddr > 8'h0C; endproperty
   a_err_only: assert property (p_err_only) else $error("spurious error");
   property p_cfg_read; rd && paddr == 8'h04 |-> prdata == {26'h000_0000, cfg}; endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
   property p_cnt_width; rd && paddr == 8'h00 |-> prdata[31:8] == 24'h00_0000; endproperty
   a_cnt_width: assert property (p_cnt_width) else $error("count wider than 8");
   property p_zero_read;
      rd && (paddr == 8'h08 || paddr > 8'h0C) |-> prdata == 32'h0000_0000;
   endproperty
   a_zero_read: assert property (p_zero_read) else $error("hidden data read");
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
endmodule : tps_timer_checker
bind tps_timer tps_timer_checker tps_timer_checker_inst (.ref_clk, .nrst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wdt_base_tick,
   .watchdog_clear_instr, .wdt_timeout_tick);

// ### tb/tps_pin_src.sv
/*
   External clock source on the count pin.
   Assumes ref_clk as time base; the pin stands still between bursts.
*/
`timescale 1ns/100ps
module tps_pin_src (
   // Time base.
   input wire logic ref_clk,
   // Count pin.
   output logic pin
);
   initial pin = 1'b0;
   // Each level lasts two to five clocks.
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         pin <= !pin;
         repeat ($urandom_range(4, 1)) @(posedge ref_clk);
      end
   endtask : edges
endmodule : tps_pin_src

// ### tb/tb_top.sv
/*
   Self-checking bench for the timer block.
   Assumes the pin source model and the bound port checker.
*/
`timescale 1ns/100ps
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, v;
   logic [7:0] a, b;
   logic pready, pslverr, er, pin, clr, tmo;
   logic tick = 1'b0;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_to = 0;
   int n;
   logic [5:0] tcfg [3] = '{6'h08, 6'h00, 6'h01};
   logic [7:0] texp [3] = '{8'h10, 8'h08, 8'h04};
   always #10 ref_clk = !ref_clk;
   tps_timer tps_timer_inst (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_count_input(pin), .wdt_base_tick(tick),
      .watchdog_clear_instr(clr), .wdt_timeout_tick(tmo));
   tps_pin_src tps_pin_src_inst (.ref_clk, .pin);
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (tmo === 1'b1) begin
         n_to <= n_to + 1;
      end
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wrcnt(input logic [31:0] d);
      apb(1'b1, 8'h00, d);
      repeat (12) @(posedge ref_clk);
   endtask : wrcnt
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge ref_clk);
         tick <= 1'b1;
         @(posedge ref_clk);
         tick <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
   endtask : ticks
   initial begin
      void'($urandom(32'hedcb));
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("config reset", 32'h0000_003F, rd);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("count after reset", 32'h0000_0000, rd);
      repeat (4) begin
         v = $urandom;
         apb(1'b1, 8'h04, v);
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("config rw", v & 32'h0000_003F, rd);
      end
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, {31'h0000_0000, er});
      $display("registers done");
      foreach (tcfg[i]) begin
         apb(1'b1, 8'h08, 32'h0000_0001);
         apb(1'b1, 8'h04, {26'h000_0000, tcfg[i]});
         wrcnt(32'h0000_00F8);
         apb(1'b0, 8'h00, 32'h0000_0000);
         a = rd[7:0];
         repeat (61) @(posedge ref_clk);
         apb(1'b0, 8'h00, 32'h0000_0000);
         b = rd[7:0];
         chk("timer delta", {24'h00_0000, texp[i]}, {24'h00_0000, 8'(b - a)});
      end
      apb(1'b1, 8'h04, 32'h0000_0008);
      v = $urandom;
      apb(1'b1, 8'h00, v);
      repeat (37) @(posedge ref_clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      b = rd[7:0] - v[7:0];
      chk("inhibit", 32'h0000_0001, {31'h0000_0000, b inside {8'h07, 8'h08}});
      $display("timer mode done");
      apb(1'b1, 8'h04, 32'h0000_0028);
      wrcnt(32'h0000_0000);
      n = $urandom_range(9, 3);
      tps_pin_src_inst.edges(2 * n);
      tps_pin_src_inst.edges(1);
      repeat (8) @(posedge ref_clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("rising count", n + 1, rd);
      apb(1'b1, 8'h04, 32'h0000_0038);
      tps_pin_src_inst.edges(2);
      repeat (8) @(posedge ref_clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("falling count", n + 2, rd);
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_0021);
      wrcnt(32'h0000_0000);
      tps_pin_src_inst.edges(2);
      wrcnt(32'h0000_0000);
      tps_pin_src_inst.edges(2);
      repeat (8) @(posedge ref_clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("prescaler cleared", 32'h0000_0000, rd);
      wrcnt(32'h0000_0000);
      tps_pin_src_inst.edges(16);
      repeat (8) @(posedge ref_clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("divided count", 32'h0000_0002, rd);
      $display("counter mode done");
      apb(1'b1, 8'h08, 32'h0000_0001);
      wrcnt(32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_000F);
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_000A);
      n = n_to;
      ticks(3);
      apb(1'b1, 8'h08, 32'h0000_0001);
      ticks(3);
      chk("wdt cleared", n, n_to);
      ticks(9);
      chk("wdt divided", n + 3, n_to);
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_0000);
      ticks(3);
      chk("wdt undivided", n + 6, n_to);
      $display("watchdog done");
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("config second reset", 32'h0000_003F, rd);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("count second reset", 32'h0000_0000, rd);
      $display("second reset done");
      report_and_stop();
   end
endmodule : tb_top
